// ==== rtl/ocp_fsm.sv ====
`timescale 1ns/1ns
module ocp_fsm #(
   parameter logic [1:0] DELAY_CODE = ocp_pkg::DELAY_CODE_4S,
   parameter longint DETECT_2S = ocp_pkg::DETECT_2S_CYC,
   parameter longint DETECT_4S = ocp_pkg::DETECT_4S_CYC,
   parameter longint DETECT_6S = ocp_pkg::DETECT_6S_CYC,
   parameter longint RELEASE = ocp_pkg::RELEASE_CYC
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [ocp_pkg::NUM_CELLS-1:0] above_detect,
   input wire logic [ocp_pkg::NUM_CELLS-1:0] above_release,
   input wire logic [ocp_pkg::NUM_CELLS-1:0] above_shutdown,
   input wire logic delay_shortening,
   output logic fuse_trigger_out,
   output logic [ocp_pkg::NUM_CELLS-1:0] detector_enabled,
   output logic shutdown
);
   import ocp_pkg::*;
   localparam longint DET_NOM = (DELAY_CODE == DELAY_CODE_2S) ? DETECT_2S :
                                (DELAY_CODE == DELAY_CODE_6S) ? DETECT_6S : DETECT_4S;
   localparam logic [CNT_W-1:0] DET_N = CNT_W'(DET_NOM);
   localparam logic [CNT_W-1:0] DET_S = CNT_W'(DET_NOM / DETECT_SHORT_DIV);
   localparam logic [CNT_W-1:0] REL_N = CNT_W'(RELEASE);
   localparam logic [CNT_W-1:0] REL_S = CNT_W'(RELEASE / RELEASE_SHORT_DIV);
   localparam logic [CNT_W-1:0] ONE = CNT_W'(1);

   logic [NUM_CELLS-1:0] det_s;
   logic [NUM_CELLS-1:0] rel_s;
   logic [NUM_CELLS-1:0] sht_s;
   logic ds_s;
   ocp_state_t state_r;
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] det_lim;
   logic [CNT_W-1:0] rel_lim;
   logic any_det;
   logic any_rel;

   ocp_sync #(.WIDTH(3 * NUM_CELLS + 1)) u_sync (
      .clk(clk),
      .arst_n(arst_n),
      .async_in({delay_shortening, above_shutdown, above_release, above_detect}),
      .sync_out({ds_s, sht_s, rel_s, det_s})
   );

   // A shorted cell reads zero volts, so it is never above the shutdown level.
   assign any_det = |(det_s & sht_s);
   assign any_rel = |rel_s;
   assign det_lim = ds_s ? DET_S : DET_N;
   assign rel_lim = ds_s ? REL_S : REL_N;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= OCP_NORMAL;
         cnt_r <= '0;
      end else begin
         case (state_r)
            OCP_NORMAL: begin
               if (!any_det) begin
                  cnt_r <= '0;
               end else if (cnt_r + ONE >= det_lim) begin
                  state_r <= OCP_OVERCHARGE;
                  cnt_r <= '0;
               end else begin
                  cnt_r <= cnt_r + ONE;
               end
            end
            OCP_OVERCHARGE: begin
               if (any_rel) begin
                  cnt_r <= '0;
               end else if (cnt_r + ONE >= rel_lim) begin
                  state_r <= OCP_NORMAL;
                  cnt_r <= '0;
               end else begin
                  cnt_r <= cnt_r + ONE;
               end
            end
            default: begin
               state_r <= OCP_NORMAL;
               cnt_r <= '0;
            end
         endcase
      end
   end

   // The output is registered so a glitch on the comparators cannot fire the fuse.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fuse_trigger_out <= 1'b0;
      end else begin
         fuse_trigger_out <= (state_r == OCP_OVERCHARGE);
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         detector_enabled <= '0;
         shutdown <= 1'b1;
      end else begin
         detector_enabled <= sht_s;
         shutdown <= ~|sht_s;
      end
   end

   // Run lengths kept for the checks only; they measure whole delays apart from cnt_r.
   // Shortening may switch mid-count, so exact lengths are checked only with it off.
   logic [CNT_W-1:0] det_run_r;
   logic [CNT_W-1:0] rel_run_r;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         det_run_r <= '0;
      end else if (state_r == OCP_NORMAL && any_det) begin
         det_run_r <= det_run_r + ONE;
      end else begin
         det_run_r <= '0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rel_run_r <= '0;
      end else if (state_r == OCP_OVERCHARGE && !any_rel) begin
         rel_run_r <= rel_run_r + ONE;
      end else begin
         rel_run_r <= '0;
      end
   end

   a_out_tracks: assert property (@(posedge clk) disable iff (!arst_n)
      fuse_trigger_out == $past(state_r == OCP_OVERCHARGE))
      else $error("fuse output does not follow state");

   a_no_early_trip: assert property (@(posedge clk) disable iff (!arst_n)
      (state_r == OCP_NORMAL && !any_det) |=> state_r == OCP_NORMAL)
      else $error("overcharge entered without detection");

   a_abort_release: assert property (@(posedge clk) disable iff (!arst_n)
      (state_r == OCP_OVERCHARGE && any_rel) |=> state_r == OCP_OVERCHARGE)
      else $error("release despite cell above release level");

   a_timer_restart: assert property (@(posedge clk) disable iff (!arst_n)
      (state_r == OCP_NORMAL && !any_det) |=> cnt_r == '0)
      else $error("detect timer not restarted");

   // The bound is the unshortened limit: a live switch to shortening may overshoot one cycle.
   a_cnt_bound: assert property (@(posedge clk) disable iff (!arst_n)
      state_r == OCP_NORMAL |-> cnt_r < DET_N)
      else $error("detect count past its limit");

   a_rel_bound: assert property (@(posedge clk) disable iff (!arst_n)
      state_r == OCP_OVERCHARGE |-> cnt_r < REL_N)
      else $error("release count past its limit");

   a_disabled_cell: assert property (@(posedge clk) disable iff (!arst_n)
      (sht_s == '0) |-> !any_det)
      else $error("disabled detector contributed");

   a_shutdown_exit: assert property (@(posedge clk) disable iff (!arst_n)
      (|sht_s) |=> !shutdown)
      else $error("shutdown not left");

   a_enter_trip: assert property (@(posedge clk) disable iff (!arst_n)
      (state_r == OCP_NORMAL && any_det && cnt_r + ONE >= det_lim)
      |=> state_r == OCP_OVERCHARGE ##1 fuse_trigger_out)
      else $error("overcharge not entered at delay end");

   a_fuse_low: assert property (@(posedge clk) disable iff (!arst_n)
      state_r == OCP_NORMAL |=> !fuse_trigger_out)
      else $error("fuse output high outside overcharge");

   a_fuse_high: assert property (@(posedge clk) disable iff (!arst_n)
      state_r == OCP_OVERCHARGE |=> fuse_trigger_out)
      else $error("fuse output low in overcharge");

   a_shutdown_flag: assert property (@(posedge clk) disable iff (!arst_n)
      shutdown == $past(~|sht_s))
      else $error("shutdown flag wrong");

   a_enable_copy: assert property (@(posedge clk) disable iff (!arst_n)
      detector_enabled == $past(sht_s))
      else $error("detector enable wrong");

   a_release_exit: assert property (@(posedge clk) disable iff (!arst_n)
      (state_r == OCP_OVERCHARGE && !any_rel && cnt_r + ONE >= rel_lim)
      |=> state_r == OCP_NORMAL)
      else $error("release not taken at delay end");

   a_det_count: assert property (@(posedge clk) disable iff (!arst_n)
      (state_r == OCP_NORMAL && any_det && cnt_r + ONE < det_lim)
      |=> cnt_r == $past(cnt_r) + ONE)
      else $error("detect timer did not advance");

   a_rel_count: assert property (@(posedge clk) disable iff (!arst_n)
      (state_r == OCP_OVERCHARGE && !any_rel && cnt_r + ONE < rel_lim)
      |=> cnt_r == $past(cnt_r) + ONE)
      else $error("release timer did not advance");

   a_release_restart: assert property (@(posedge clk) disable iff (!arst_n)
      (state_r == OCP_OVERCHARGE && any_rel) |=> cnt_r == '0)
      else $error("release timer not restarted");

   a_det_length: assert property (@(posedge clk) disable iff (!arst_n)
      ($rose(state_r == OCP_OVERCHARGE) && !$past(ds_s)) |-> det_run_r == DET_N)
      else $error("detect delay length wrong");

   a_det_short: assert property (@(posedge clk) disable iff (!arst_n)
      ($rose(state_r == OCP_OVERCHARGE) && $past(ds_s))
      |-> (det_run_r >= DET_S && det_run_r <= DET_N))
      else $error("shortened detect delay out of range");

   a_rel_length: assert property (@(posedge clk) disable iff (!arst_n)
      ($fell(state_r == OCP_OVERCHARGE) && !$past(ds_s)) |-> rel_run_r == REL_N)
      else $error("release delay length wrong");

   a_rel_short: assert property (@(posedge clk) disable iff (!arst_n)
      ($fell(state_r == OCP_OVERCHARGE) && $past(ds_s))
      |-> (rel_run_r >= REL_S && rel_run_r <= REL_N))
      else $error("shortened release delay out of range");
endmodule : ocp_fsm

// ==== rtl/ocp_sync.sv ====
`timescale 1ns/1ns
module ocp_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   import ocp_pkg::*;
   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] s2_r;
   logic [WIDTH-1:0] s3_r;
   // A change is accepted only once the second and third stages agree.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         sync_out <= '0;
      end else begin
         meta_r <= async_in;
         s2_r <= meta_r;
         s3_r <= s2_r;
         for (int i = 0; i < WIDTH; i++) begin
            if (s2_r[i] == s3_r[i]) begin
               sync_out[i] <= s3_r[i];
            end
         end
      end
   end
endmodule : ocp_sync

// ==== shared/ocp_pkg.sv ====
package ocp_pkg;
   localparam int NUM_CELLS = 3;
   localparam longint CLK_HZ = 20000000;
   // Detect delay selection codes and their nominal lengths in milliseconds.
   localparam logic [1:0] DELAY_CODE_2S = 2'h0;
   localparam logic [1:0] DELAY_CODE_4S = 2'h1;
   localparam logic [1:0] DELAY_CODE_6S = 2'h2;
   localparam longint DETECT_DELAY_2S_MS = 2000;
   localparam longint DETECT_DELAY_4S_MS = 4000;
   localparam longint DETECT_DELAY_6S_MS = 6000;
   localparam longint RELEASE_DELAY_US = 16000;
   localparam longint DETECT_SHORT_DIV = 90;
   localparam longint RELEASE_SHORT_DIV = 60;
   localparam longint DETECT_2S_CYC = DETECT_DELAY_2S_MS * CLK_HZ / 1000;
   localparam longint DETECT_4S_CYC = DETECT_DELAY_4S_MS * CLK_HZ / 1000;
   localparam longint DETECT_6S_CYC = DETECT_DELAY_6S_MS * CLK_HZ / 1000;
   localparam longint RELEASE_CYC = RELEASE_DELAY_US * CLK_HZ / 1000000;
   localparam int CNT_W = 32;
   localparam int SYNC_STAGES = 3;
   typedef enum logic [0:0] {OCP_NORMAL, OCP_OVERCHARGE} ocp_state_t;
endpackage : ocp_pkg

// ==== tb/ocp_fuse_model.sv ====
`timescale 1ns/1ns
// Transistor and fuse in the charge path: once blown the path stays open for good.
module ocp_fuse_model (
   input wire logic clk,
   input wire logic gate,
   output logic fuse_open
);
   initial fuse_open = 1'b0;
   always @(posedge clk) begin
      if (gate === 1'b1) begin
         fuse_open <= 1'b1;
      end
   end
endmodule : ocp_fuse_model

// ==== tb/overcharge_protect_fsm_bench.sv ====
`timescale 1ns/1ns
module overcharge_protect_fsm_bench;
   import ocp_pkg::*;
   logic clk, arst_n, ds, sd, fuse, fopen;
   logic [NUM_CELLS-1:0] det, rel, shd, den;
   int errors = 0;
   int comparisons = 0;
   int n;
   ocp_fsm #(.DETECT_4S(360), .RELEASE(120)) i_ocp_fsm (.clk(clk), .arst_n(arst_n),
      .above_detect(det), .above_release(rel), .above_shutdown(shd),
      .delay_shortening(ds), .fuse_trigger_out(fuse), .detector_enabled(den),
      .shutdown(sd));
   ocp_fuse_model i_ocp_fuse_model (.clk(clk), .gate(fuse), .fuse_open(fopen));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic tally_and_finish;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic seen, input logic exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: seen %b expected %b", $time, seen, exp);
      end
   endtask : chk
   task automatic idle(input int c);
      repeat (c) @(negedge clk);
   endtask : idle
   // Counts cycles until the fuse drive reaches v; a run-out is a hang.
   task automatic wait_fuse(input logic v, input int lim);
      n = 0;
      while (fuse !== v && n < lim) begin
         @(negedge clk);
         n++;
      end
      if (n >= lim) begin
         errors++;
         tally_and_finish();
      end
   endtask : wait_fuse
   task automatic t_detect;
      det = 3'h1;
      rel = 3'h1;
      wait_fuse(1'b1, 600);
      chk(n >= 288 && n <= 432, 1'b1);
      idle(2);
      chk(fopen, 1'b1);
   endtask : t_detect
   // A short release attempt must be thrown away, so the fall counts from the last dip.
   task automatic t_release;
      det = 3'h0;
      rel = 3'h0;
      idle(60);
      rel = 3'h2;
      idle(10);
      rel = 3'h0;
      wait_fuse(1'b0, 400);
      chk(n >= 96 && n <= 144, 1'b1);
   endtask : t_release
   task automatic t_shutdown;
      shd = 3'h3;
      det = 3'h4;
      idle(500);
      chk(fuse, 1'b0);
      chk(den === 3'h3, 1'b1);
      shd = 3'h0;
      idle(10);
      chk(sd, 1'b1);
      shd = 3'h1;
      idle(10);
      chk(sd, 1'b0);
      det = 3'h0;
      shd = 3'h7;
   endtask : t_shutdown
   task automatic t_restart;
      det = 3'h2;
      idle(250);
      det = 3'h0;
      idle(10);
      det = 3'h2;
      wait_fuse(1'b1, 600);
      chk(n >= 288 && n <= 432, 1'b1);
      det = 3'h0;
      rel = 3'h0;
      wait_fuse(1'b0, 400);
   endtask : t_restart
   task automatic t_short;
      ds = 1'b1;
      det = 3'h1;
      rel = 3'h1;
      wait_fuse(1'b1, 60);
      chk(n <= 14, 1'b1);
      det = 3'h0;
      rel = 3'h0;
      wait_fuse(1'b0, 60);
      chk(n <= 12, 1'b1);
      ds = 1'b0;
   endtask : t_short
   initial begin
      arst_n = 1'b0;
      det = 3'h0;
      rel = 3'h0;
      shd = 3'h7;
      ds = 1'b0;
      idle(20);
      chk(fuse, 1'b0);
      chk(sd, 1'b1);
      arst_n = 1'b1;
      idle(5);
      t_detect();
      t_release();
      t_shutdown();
      t_restart();
      t_short();
      tally_and_finish();
   end
endmodule : overcharge_protect_fsm_bench
